// file: pkg/edas_defines.svh
`ifndef EDAS_DEFINES_SVH
`define EDAS_DEFINES_SVH

// Register indices; byte address is four times the index
`define EDAS_IDX_DP0_LO   8'h82
`define EDAS_IDX_DP0_HI   8'h83
`define EDAS_IDX_DP1_LO   8'h84
`define EDAS_IDX_DP1_HI   8'h85
`define EDAS_IDX_PSEL     8'h86
`define EDAS_IDX_CLKCTRL  8'h8e
`define EDAS_IDX_PORT2    8'ha0

// Field positions
`define EDAS_PSEL_BIT     0
`define EDAS_STRETCH_MSB  2
`define EDAS_STRETCH_LSB  0

// Reset values
`define EDAS_STRETCH_RST  3'h1
`define EDAS_CLKCTRL_RST  8'h01
`define EDAS_PORT2_RST    8'hff
`define EDAS_DP_RST       16'h0000

// Timing counts in clocks
`define EDAS_FETCH_LAST   6'h03
`define EDAS_STB0_FIRST   6'h01
`define EDAS_STB0_LAST    6'h02
`define EDAS_STBN_FIRST   6'h02

`endif

// file: pkg/edas_pkg.sv
package edas_pkg;

    typedef enum logic [3:0] {
        PH_C1 = 4'b0001,
        PH_C2 = 4'b0010,
        PH_C3 = 4'b0100,
        PH_C4 = 4'b1000
    } edas_phase_e;

    typedef enum logic [2:0] {
        ST_IDLE   = 3'b001,
        ST_FETCH  = 3'b010,
        ST_ACCESS = 3'b100
    } edas_state_e;

    typedef struct packed {
        logic       write;
        logic       use_ptr;
        logic [7:0] index_low;
        logic [7:0] wdata;
    } edas_req_s;

    typedef struct packed {
        logic inc_data_pointer_zero;
        logic sel_inc;
        logic sel_dec;
    } edas_ptrop_s;

endpackage

// file: logic/edas_top.sv
// Our own choice: the Wishbone interface to the registers.
`timescale 1ns/100ps
`default_nettype none
`include "edas_defines.svh"

// Overview of operation
// - Indirect form takes address low byte from the indirect index register.
// - Indirect form takes address high byte from the port 2 register.
// - Pointer form drives all 16 address bits from the selected pointer.
// - Pointer select bit is bit 0 of the register at index 86h.
// - Other pointer select bits do nothing and always read zero.
// - Select bit 0 picks pointer zero, 1 picks pointer one.
// - Incrementing or decrementing the select register toggles the chosen pointer.
// - A transfer starts with a normal four clock opcode fetch cycle.
// - The next stretch plus one machine cycles drive the address and do the access.
// - Stretch value lives in bits 2 to 0 of clock control register.
// - Stretch 0 to 7 gives transfers of 2 to 9 machine cycles.
// - Stretch resets to 1, giving a three machine cycle transfer.
// - Strobe lasts 2 clocks at stretch 0, otherwise four times stretch.
// - Only the transfer is lengthened; the core is held meanwhile.
// - Memory and mapped peripherals share the same external bus cycle.
// - Each machine cycle has four states in fixed order C1 to C4.
module edas_top (
    input  wire logic              clk_i,
    input  wire logic              rst_i,
    input  wire logic              wb_cyc_i,
    input  wire logic              wb_stb_i,
    input  wire logic              wb_we_i,
    input  wire logic [11:0]       wb_adr_i,
    input  wire logic [3:0]        wb_sel_i,
    input  wire logic [31:0]       wb_dat_i,
    output var  logic [31:0]       wb_dat_o,
    output var  logic              wb_ack_o,
    input  wire logic              req_valid_i,
    input  wire edas_pkg::edas_req_s req_i,
    output var  logic              req_ready_o,
    input  wire edas_pkg::edas_ptrop_s ptr_op_i,
    output var  logic              busy_o,
    output var  logic              done_o,
    output var  logic [7:0]        rdata_o,
    output var  logic [3:0]        phase_o,
    output var  logic [15:0]       ext_addr_o,
    output var  logic [7:0]        ext_data_o,
    output var  logic              ext_data_oe_o,
    input  wire logic [7:0]        ext_data_i,
    output var  logic              ext_rd_n_o,
    output var  logic              ext_wr_n_o
);
    import edas_pkg::*;

    function automatic logic strobe_on(input logic [2:0] s, input logic [5:0] c);
        logic [5:0] last;
        last = {1'b0, s, 2'b01};
        if (s == 3'h0) begin
            strobe_on = (c >= `EDAS_STB0_FIRST) && (c <= `EDAS_STB0_LAST);
        end else begin
            strobe_on = (c >= `EDAS_STBN_FIRST) && (c <= last);
        end
    endfunction

    // Machine cycle states
    edas_phase_e phase_reg, phase_next;

    always_comb begin
        case (phase_reg)
            PH_C1:   phase_next = PH_C2;
            PH_C2:   phase_next = PH_C3;
            PH_C3:   phase_next = PH_C4;
            PH_C4:   phase_next = PH_C1;
            default: phase_next = PH_C1;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            phase_reg <= PH_C1;
        end else begin
            phase_reg <= phase_next;
        end
    end

    // Register file
    logic [15:0] dp0_reg, dp0_next, dp1_reg, dp1_next;
    logic        psel_reg, psel_next;
    logic [2:0]  stretch_reg, stretch_next;
    logic [7:0]  port2_reg, port2_next;
    logic [31:0] dat_reg, dat_next;
    logic        ack_reg, ack_next;
    logic        wb_hit, wb_wr;
    logic [7:0]  wb_idx;
    logic [15:0] dp_sel;

    assign wb_idx = wb_adr_i[9:2];
    assign wb_hit = wb_cyc_i && wb_stb_i && !ack_reg;
    assign wb_wr  = wb_hit && wb_we_i && wb_sel_i[0] && (wb_adr_i[11:10] == 2'b00);
    assign dp_sel = psel_reg ? dp1_reg : dp0_reg;

    always_comb begin
        dp0_next     = dp0_reg;
        dp1_next     = dp1_reg;
        psel_next    = psel_reg;
        stretch_next = stretch_reg;
        port2_next   = port2_reg;
        dat_next     = 32'h0000_0000;
        ack_next     = wb_hit;
        if (ptr_op_i.sel_inc || ptr_op_i.sel_dec) begin
            psel_next = !psel_reg;
        end
        if (ptr_op_i.inc_data_pointer_zero) begin
            if (psel_reg) begin
                dp1_next = dp1_reg + 16'h0001;
            end else begin
                dp0_next = dp0_reg + 16'h0001;
            end
        end
        if (wb_wr) begin
            case (wb_idx)
                `EDAS_IDX_DP0_LO:  dp0_next[7:0]  = wb_dat_i[7:0];
                `EDAS_IDX_DP0_HI:  dp0_next[15:8] = wb_dat_i[7:0];
                `EDAS_IDX_DP1_LO:  dp1_next[7:0]  = wb_dat_i[7:0];
                `EDAS_IDX_DP1_HI:  dp1_next[15:8] = wb_dat_i[7:0];
                `EDAS_IDX_PSEL:    psel_next = wb_dat_i[`EDAS_PSEL_BIT];
                `EDAS_IDX_CLKCTRL: begin
                    stretch_next = wb_dat_i[`EDAS_STRETCH_MSB:`EDAS_STRETCH_LSB];
                end
                `EDAS_IDX_PORT2:   port2_next = wb_dat_i[7:0];
                default:           dat_next = 32'h0000_0000;
            endcase
        end
        if (wb_hit && !wb_we_i && (wb_adr_i[11:10] == 2'b00)) begin
            case (wb_idx)
                `EDAS_IDX_DP0_LO:  dat_next[7:0] = dp0_reg[7:0];
                `EDAS_IDX_DP0_HI:  dat_next[7:0] = dp0_reg[15:8];
                `EDAS_IDX_DP1_LO:  dat_next[7:0] = dp1_reg[7:0];
                `EDAS_IDX_DP1_HI:  dat_next[7:0] = dp1_reg[15:8];
                `EDAS_IDX_PSEL:    dat_next[0]   = psel_reg;
                `EDAS_IDX_CLKCTRL: dat_next[2:0] = stretch_reg;
                `EDAS_IDX_PORT2:   dat_next[7:0] = port2_reg;
                default:           dat_next      = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dp0_reg     <= `EDAS_DP_RST;
            dp1_reg     <= `EDAS_DP_RST;
            psel_reg    <= 1'b0;
            stretch_reg <= `EDAS_STRETCH_RST;
            port2_reg   <= `EDAS_PORT2_RST;
            dat_reg     <= 32'h0000_0000;
            ack_reg     <= 1'b0;
        end else begin
            dp0_reg     <= dp0_next;
            dp1_reg     <= dp1_next;
            psel_reg    <= psel_next;
            stretch_reg <= stretch_next;
            port2_reg   <= port2_next;
            dat_reg     <= dat_next;
            ack_reg     <= ack_next;
        end
    end

    // Read data pins pass two flops before use
    logic [7:0] sync1_reg, sync2_reg;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sync1_reg <= 8'h00;
            sync2_reg <= 8'h00;
        end else begin
            sync1_reg <= ext_data_i;
            sync2_reg <= sync1_reg;
        end
    end

    // Transfer sequencer; one bus cycle serves memory and mapped peripherals
    edas_state_e state_reg, state_next;
    logic [5:0]  cnt_reg, cnt_next;
    logic [2:0]  lat_str_reg, lat_str_next;
    logic [15:0] lat_addr_reg, lat_addr_next;
    logic        lat_wr_reg, lat_wr_next;
    logic [7:0]  lat_wd_reg, lat_wd_next;
    logic [15:0] addr_reg, addr_next;
    logic [7:0]  rdata_reg, rdata_next;
    logic        rd_n_reg, rd_n_next, wr_n_reg, wr_n_next, oe_reg, oe_next;
    logic        ready_reg, ready_next, busy_reg, busy_next, done_reg, done_next;
    logic        accept, stb_next;
    logic [15:0] addr_src;
    logic [5:0]  acc_last;

    assign accept   = req_valid_i && ready_reg;
    assign addr_src = req_i.use_ptr ? dp_sel : {port2_reg, req_i.index_low};
    assign acc_last = {1'b0, lat_str_reg, 2'b11};

    always_comb begin
        state_next    = state_reg;
        cnt_next      = cnt_reg + 6'h01;
        lat_str_next  = lat_str_reg;
        lat_addr_next = lat_addr_reg;
        lat_wr_next   = lat_wr_reg;
        lat_wd_next   = lat_wd_reg;
        addr_next     = addr_reg;
        rdata_next    = rdata_reg;
        done_next     = 1'b0;
        case (state_reg)
            ST_IDLE: begin
                cnt_next = 6'h00;
                if (accept) begin
                    state_next    = ST_FETCH;
                    lat_str_next  = stretch_reg;
                    lat_addr_next = addr_src;
                    lat_wr_next   = req_i.write;
                    lat_wd_next   = req_i.wdata;
                end
            end
            ST_FETCH: begin
                if (cnt_reg == `EDAS_FETCH_LAST) begin
                    state_next = ST_ACCESS;
                    cnt_next   = 6'h00;
                    addr_next  = lat_addr_reg;
                end
            end
            ST_ACCESS: begin
                if (cnt_reg == acc_last) begin
                    state_next = ST_IDLE;
                    cnt_next   = 6'h00;
                    done_next  = 1'b1;
                    if (!lat_wr_reg) begin
                        rdata_next = sync2_reg;
                    end
                end
            end
            default: begin
                state_next = ST_IDLE;
                cnt_next   = 6'h00;
            end
        endcase
        stb_next   = (state_next == ST_ACCESS) && strobe_on(lat_str_reg, cnt_next);
        rd_n_next  = !(stb_next && !lat_wr_reg);
        wr_n_next  = !(stb_next && lat_wr_reg);
        oe_next    = (state_next == ST_ACCESS) && lat_wr_reg;
        busy_next  = state_next != ST_IDLE;
        ready_next = (state_next == ST_IDLE) && (phase_next == PH_C4);
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_reg    <= ST_IDLE;
            cnt_reg      <= 6'h00;
            lat_str_reg  <= `EDAS_STRETCH_RST;
            lat_addr_reg <= 16'h0000;
            lat_wr_reg   <= 1'b0;
            lat_wd_reg   <= 8'h00;
            addr_reg     <= 16'h0000;
            rdata_reg    <= 8'h00;
            rd_n_reg     <= 1'b1;
            wr_n_reg     <= 1'b1;
            oe_reg       <= 1'b0;
            busy_reg     <= 1'b0;
            ready_reg    <= 1'b0;
            done_reg     <= 1'b0;
        end else begin
            state_reg    <= state_next;
            cnt_reg      <= cnt_next;
            lat_str_reg  <= lat_str_next;
            lat_addr_reg <= lat_addr_next;
            lat_wr_reg   <= lat_wr_next;
            lat_wd_reg   <= lat_wd_next;
            addr_reg     <= addr_next;
            rdata_reg    <= rdata_next;
            rd_n_reg     <= rd_n_next;
            wr_n_reg     <= wr_n_next;
            oe_reg       <= oe_next;
            busy_reg     <= busy_next;
            ready_reg    <= ready_next;
            done_reg     <= done_next;
        end
    end

    assign wb_dat_o      = dat_reg;
    assign wb_ack_o      = ack_reg;
    assign req_ready_o   = ready_reg;
    assign busy_o        = busy_reg;
    assign done_o        = done_reg;
    assign rdata_o       = rdata_reg;
    assign phase_o       = phase_reg;
    assign ext_addr_o    = addr_reg;
    assign ext_data_o    = lat_wd_reg;
    assign ext_data_oe_o = oe_reg;
    assign ext_rd_n_o    = rd_n_reg;
    assign ext_wr_n_o    = wr_n_reg;

    // Checking helpers
    logic [5:0] stb_len_reg;
    logic [6:0] busy_len_reg;
    logic       stb_act;

    assign stb_act = !rd_n_reg || !wr_n_reg;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            stb_len_reg  <= 6'h00;
            busy_len_reg <= 7'h00;
        end else begin
            stb_len_reg  <= stb_act ? stb_len_reg + 6'h01 : 6'h00;
            busy_len_reg <= busy_reg ? busy_len_reg + 7'h01 : 7'h00;
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence s_fetch_quiet;
        (rd_n_reg && wr_n_reg && busy_reg) [*4];
    endsequence

    sequence s_phase_round;
        (phase_reg == PH_C2) ##1 (phase_reg == PH_C3) ##1 (phase_reg == PH_C4);
    endsequence

    a_phase_order: assert property ((phase_reg == PH_C1) |=> s_phase_round)
        else $error("machine cycle states out of order");

    a_fetch_first: assert property (accept |=> s_fetch_quiet)
        else $error("strobe during opcode fetch cycle");

    a_addr_source: assert property (accept |-> ##5 (ext_addr_o == $past(addr_src, 5)))
        else $error("external address not taken from its source");

    a_strobe_width: assert property (($fell(stb_act)) |->
        (stb_len_reg == ((lat_str_reg == 3'h0) ? 6'h02 : {1'b0, lat_str_reg, 2'b00})))
        else $error("strobe width wrong");

    a_xfer_length: assert property ($fell(busy_reg) |->
        (busy_len_reg == {2'b00, lat_str_reg, 2'b00} + 7'h08))
        else $error("transfer length wrong");

    a_addr_stable: assert property ((stb_act && $past(stb_act)) |-> $stable(ext_addr_o))
        else $error("address moved during strobe");

    a_psel_read: assert property ((wb_ack_o && $past(wb_idx) == `EDAS_IDX_PSEL) |->
        (wb_dat_o[31:1] == 31'h0))
        else $error("pointer select upper bits not zero");

    a_psel_toggle: assert property ((ptr_op_i.sel_inc && !wb_wr) |=> (psel_reg != $past(psel_reg)))
        else $error("select increment did not toggle");

    a_stretch_reset: assert property ($past(rst_i) |-> (stretch_reg == `EDAS_STRETCH_RST))
        else $error("stretch reset value wrong");

    a_done_busy: assert property (done_reg |-> !busy_reg ##1 !done_reg)
        else $error("done pulse malformed");

endmodule // edas_top

`default_nettype wire

// file: tb/edas_ext_mem.sv
`timescale 1ns/100ps
`default_nettype none
// Behavioural external data memory; read data is a fixed function of the address once lat_i strobe cycles have passed
module edas_ext_mem (
    input  wire logic        clk_i,
    input  wire logic [15:0] addr_i,
    input  wire logic [7:0]  data_i,
    input  wire logic        rd_n_i,
    input  wire logic        wr_n_i,
    input  wire logic [4:0]  lat_i,
    output var  logic [7:0]  data_o,
    output var  logic [15:0] stb_addr_o,
    output var  logic        stable_o,
    output var  logic        was_wr_o,
    output var  logic [5:0]  len_o,
    output var  logic [15:0] wr_addr_o,
    output var  logic [7:0]  wr_data_o
);
    int         cnt = 0;
    logic [7:0] last = 8'h00;

    // Slow memory: data only after lat_i strobe cycles, else a changing pattern
    always_comb begin
        if (!rd_n_i && cnt >= int'(lat_i)) begin
            data_o = addr_i[15:8] ^ addr_i[7:0] ^ 8'h5a;
        end else begin
            data_o = ~last;
        end
    end

    always @(posedge clk_i) begin
        last <= data_o;
        if (!rd_n_i || !wr_n_i) begin
            if (cnt == 0) begin
                stb_addr_o <= addr_i;
                stable_o <= 1'b1;
                was_wr_o <= !wr_n_i;
            end else if (addr_i !== stb_addr_o) begin
                stable_o <= 1'b0;
            end
            cnt <= cnt + 1;
        end else if (cnt != 0) begin
            len_o <= 6'(cnt);
            cnt <= 0;
            if (was_wr_o) begin
                wr_addr_o <= stb_addr_o;
                wr_data_o <= data_i;
            end
        end
    end
endmodule // edas_ext_mem
`default_nettype wire

// file: tb/tb_ext_data_access_stretch.sv
`timescale 1ns/100ps
`default_nettype none
`include "edas_defines.svh"
module tb_ext_data_access_stretch;
    import edas_pkg::*;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, req_valid_i = 1'b0;
    logic [11:0] wb_adr_i = 12'h000;
    logic [3:0]  wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o;
    logic        wb_ack_o, req_ready_o, busy_o, done_o, ext_data_oe_o, ext_rd_n_o, ext_wr_n_o;
    edas_req_s   req_i = '0;
    edas_ptrop_s ptr_op_i = '0;
    logic [7:0]  rdata_o, ext_data_o, ext_data_i, mem_out, m_wdata;
    logic [3:0]  phase_o;
    logic [15:0] ext_addr_o, m_addr, m_waddr;
    logic        m_stable, m_wr;
    logic [5:0]  m_len;
    logic [4:0]  lat = 5'h00;
    int          n_errors = 0, checked = 0, cycles = 0, seed = 94;
    logic [7:0]  r_idx [7] = '{`EDAS_IDX_DP0_LO, `EDAS_IDX_DP0_HI, `EDAS_IDX_DP1_LO,
        `EDAS_IDX_DP1_HI, `EDAS_IDX_PSEL, `EDAS_IDX_CLKCTRL, `EDAS_IDX_PORT2};
    logic [7:0]  r_rst [7] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'hff};

    always #20 clk_i = ~clk_i;
    // Shared data wire: the design drives it only while its enable is high
    assign ext_data_i = ext_data_oe_o ? ext_data_o : mem_out;

    edas_top i_edas_top (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
        .wb_dat_i, .wb_dat_o, .wb_ack_o, .req_valid_i, .req_i, .req_ready_o, .ptr_op_i, .busy_o,
        .done_o, .rdata_o, .phase_o, .ext_addr_o, .ext_data_o, .ext_data_oe_o, .ext_data_i,
        .ext_rd_n_o, .ext_wr_n_o);
    edas_ext_mem i_edas_ext_mem (.clk_i, .addr_i(ext_addr_o), .data_i(ext_data_i),
        .rd_n_i(ext_rd_n_o), .wr_n_i(ext_wr_n_o), .lat_i(lat), .data_o(mem_out),
        .stb_addr_o(m_addr), .stable_o(m_stable), .was_wr_o(m_wr), .len_o(m_len),
        .wr_addr_o(m_waddr), .wr_data_o(m_wdata));

    function automatic logic [11:0] ba(logic [7:0] idx);
        return {2'b00, idx, 2'b00};
    endfunction

    function automatic logic [31:0] exp_width(logic [2:0] s);
        return (s == 3'h0) ? 32'h0000_0002 : {27'h000_0000, s, 2'b00};
    endfunction

    // Same pattern the memory model returns for a read
    function automatic logic [7:0] exp_rdata(logic [15:0] a);
        return a[15:8] ^ a[7:0] ^ 8'h5a;
    endfunction

    task automatic print_verdict;
        $display("mismatches %0d comparisons %0d", n_errors, checked);
        if (n_errors == 0 && checked > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wb(logic we, logic [11:0] adr, logic [7:0] d, output logic [7:0] q);
        int n;
        n = 0;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_dat_i <= {24'h0, d};
        wb_sel_i <= 4'h1;
        do begin @(posedge clk_i); n++; end while (wb_ack_o !== 1'b1 && n < 20);
        q = wb_dat_o[7:0];
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        chk("bus ack", wb_ack_o, 1'b1);
    endtask

    task automatic op(edas_ptrop_s v);
        @(posedge clk_i);
        ptr_op_i <= v;
        @(posedge clk_i);
        ptr_op_i <= '0;
    endtask

    task automatic xfer(logic w, logic p, logic [7:0] idx, logic [7:0] wd, logic [15:0] ea,
                        logic [2:0] s);
        int n, nb;
        n = 0;
        nb = 0;
        do @(posedge clk_i); while (phase_o !== PH_C3);
        req_valid_i <= 1'b1;
        req_i <= '{w, p, idx, wd};
        @(posedge clk_i);
        req_valid_i <= 1'b0;
        chk("ready in c4", req_ready_o, 1'b1);
        do begin @(posedge clk_i); n++; nb += int'(busy_o === 1'b1); end
        while (done_o !== 1'b1 && n < 60);
        chk("done delay", n, 4 * (s + 2) + 1);
        chk("busy cycles", nb, 4 * (s + 2));
        // Busy ends on a C4, so the done pulse shows in the following C1
        chk("done phase", phase_o, PH_C1);
        chk("strobe width", m_len, exp_width(s));
        chk("strobe kind", m_wr, w);
        chk("ext address", m_addr, ea);
        chk("addr stable", m_stable, 1'b1);
        if (w) chk("write data", {m_waddr, m_wdata}, {ea, wd});
        else chk("read data", rdata_o, exp_rdata(ea));
    endtask

    always @(posedge clk_i) begin
        cycles++;
        if (cycles >= 8000) begin
            n_errors++;
            print_verdict;
        end
    end

    initial begin
        logic [7:0]  q, idx, wd, p2;
        logic [15:0] d0, d1, ea;
        logic [2:0]  s;
        logic        w, p, sl;
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        for (int i = 0; i < 8; i++) begin
            q[3:0] = phase_o;
            @(posedge clk_i);
            chk("phase order", phase_o, {q[2:0], q[3]});
        end
        for (int i = 0; i < 7; i++) begin
            wb(1'b0, ba(r_idx[i]), 8'h00, q);
            chk("reset value", q, r_rst[i]);
        end
        wb(1'b0, 12'h004, 8'h00, q);
        chk("unmapped read", q, 8'h00);
        wb(1'b1, 12'he18, 8'h01, q);
        wb(1'b0, ba(`EDAS_IDX_PSEL), 8'h00, q);
        chk("refused write", q, 8'h00);
        wb(1'b1, ba(`EDAS_IDX_PSEL), 8'hff, q);
        wb(1'b0, ba(`EDAS_IDX_PSEL), 8'h00, q);
        chk("select bits", q, 8'h01);
        op('{1'b0, 1'b1, 1'b0});
        wb(1'b0, ba(`EDAS_IDX_PSEL), 8'h00, q);
        chk("select inc", q, 8'h00);
        op('{1'b0, 1'b0, 1'b1});
        wb(1'b0, ba(`EDAS_IDX_PSEL), 8'h00, q);
        chk("select dec", q, 8'h01);
        wb(1'b1, ba(`EDAS_IDX_DP1_LO), 8'hff, q);
        wb(1'b1, ba(`EDAS_IDX_DP1_HI), 8'h12, q);
        op('{1'b1, 1'b0, 1'b0});
        wb(1'b0, ba(`EDAS_IDX_DP1_LO), 8'h00, q);
        chk("pointer one low", q, 8'h00);
        wb(1'b0, ba(`EDAS_IDX_DP1_HI), 8'h00, q);
        chk("pointer one high", q, 8'h13);
        wb(1'b0, ba(`EDAS_IDX_DP0_LO), 8'h00, q);
        chk("pointer zero low", q, 8'h00);
        for (int k = 0; k < 24; k++) begin
            s = (k < 8) ? k[2:0] : 3'($random(seed));
            {w, p, sl, idx, wd, p2} = 27'($random(seed));
            {d0, d1} = $random(seed);
            wb(1'b1, ba(`EDAS_IDX_CLKCTRL), {5'h00, s}, q);
            wb(1'b0, ba(`EDAS_IDX_CLKCTRL), 8'h00, q);
            chk("stretch field", q[2:0], s);
            wb(1'b1, ba(`EDAS_IDX_PSEL), {7'h00, sl}, q);
            wb(1'b1, ba(`EDAS_IDX_PORT2), p2, q);
            wb(1'b1, ba(`EDAS_IDX_DP0_LO), d0[7:0], q);
            wb(1'b1, ba(`EDAS_IDX_DP0_HI), d0[15:8], q);
            wb(1'b1, ba(`EDAS_IDX_DP1_LO), d1[7:0], q);
            wb(1'b1, ba(`EDAS_IDX_DP1_HI), d1[15:8], q);
            ea = p ? (sl ? d1 : d0) : {p2, idx};
            lat <= (s == 3'h0) ? 5'h00 : 5'({$random(seed)} % (4 * s - 1));
            xfer(w, p, idx, wd, ea, s);
        end
        print_verdict;
    end
endmodule // tb_ext_data_access_stretch
`default_nettype wire
